//--- src/cts_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit byte addresses on the register bus
// Notes: Included by bare name, definitions only
`ifndef CTS_REGS_SVH
`define CTS_REGS_SVH

`define CTS_A_CTRL 8'h00
`define CTS_A_HI 8'h04
`define CTS_A_LO 8'h08
`define CTS_A_RATIO 8'h0C
`define CTS_A_SEQ 8'h10
`define CTS_A_SDIF 8'h14
`define CTS_A_DLY 8'h18
`define CTS_A_STAT 8'h1C
`define CTS_A_CNT 8'h20
`define CTS_A_MAG 8'h24
`define CTS_A_ANG 8'h28
`define CTS_A_RSEL 8'h2C
`define CTS_A_REC0 8'h30
`define CTS_A_REC5 8'h44

`define CTS_CTRL_CLR 0
`define CTS_CTRL_RES 1
`define CTS_CTRL_ASEL 2
`define CTS_CTRL_BSEL 4

`define CTS_RST_CTRL 6'h3C
`define CTS_RST_HI 16'h0078
`define CTS_RST_LO 16'h000A
`define CTS_RST_RATIO 16'h03E8
`define CTS_RST_SEQ 16'h1324
`define CTS_RST_SDIF 16'h000A
`define CTS_RST_DLY 19'h0_0064

`define CTS_PCT 32'h0000_0064
`define CTS_HYS_LO 32'h0000_0061
`define CTS_HYS_HI 32'h0000_0067
`define CTS_RSCALE 32'h0000_2710

`define CTS_EV_ALM_ON 2'h0
`define CTS_EV_ALM_OFF 2'h1
`define CTS_EV_BLK_ON 2'h2
`define CTS_EV_BLK_OFF 2'h3

`define CTS_REC_N 4'hC

`define CTS_CYC_MS 5
`define CTS_CLK_KHZ 125000
`define CTS_CYC_CYCLES (`CTS_CYC_MS * `CTS_CLK_KHZ)

`endif

//--- src/cts_pkg.sv
// Purpose: Types shared by the supervision block and its record store
// Assumes: Currents in 0.01 x In steps, angles in 0.01 deg steps
// Notes: Record layout is six 32-bit words, word 0 lowest
package cts_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_ALARM, ST_BLOCK}
      cts_state_e;

   typedef struct packed {
      logic [15:0] i_l1;
      logic [15:0] i_l2;
      logic [15:0] i_l3;
      logic [15:0] i_res;
      logic [15:0] i_sum;
      logic [15:0] i_pos;
      logic [15:0] i_neg;
      logic [15:0] ang_sum;
      logic [15:0] ang_res;
   } cts_meas_s;

   typedef struct packed {
      logic valid;
      logic [1:0] code;
      logic store;
      logic [31:0] stamp;
   } cts_evt_s;

   typedef struct packed {
      logic [22:0] pad5;
      logic [2:0] group;
      logic [3:0] fault;
      logic [1:0] code;
      logic [12:0] pad4;
      logic [18:0] remain;
      logic [15:0] i_neg;
      logic [15:0] i_pos;
      logic [15:0] i_res;
      logic [15:0] i_l3;
      logic [15:0] i_l2;
      logic [15:0] i_l1;
      logic [31:0] stamp;
   } cts_rec_s;

   typedef struct packed {
      cts_rec_s [11:0] mem;
      cts_rec_s rd;
   } cts_mem_s;

   typedef struct packed {
      logic [15:0] hi;
      logic [15:0] lo;
      logic [15:0] ratio;
      logic [15:0] seq;
      logic [15:0] sdif;
      logic [18:0] dly;
      logic [5:0] ctrl;
      logic [3:0] rsel;
   } cts_cfg_s;

   typedef struct packed {
      cts_cfg_s cfg;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rstage;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_have;
      logic w_have;
      logic [7:0] awaddr;
      logic [7:0] araddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic clr;
      logic [19:0] prg_cnt;
      logic eval;
      logic blk_s;
      cts_state_e state;
      logic [18:0] timer;
      logic hi_over;
      logic lo_under;
      logic [3:0] flt;
      logic start;
      logic alarm;
      logic blocked;
      cts_evt_s evt;
      logic [15:0] alm_cnt;
      logic [15:0] blk_cnt;
      logic [3:0] wr_ptr;
      logic [3:0] rec_n;
      logic we;
      logic [3:0] waddr;
      cts_rec_s wrec;
      logic [15:0] mag_diff;
      logic [16:0] ang_diff;
   } cts_st_s;

endpackage

//--- src/cts_rec_mem.sv
// Purpose: Twelve-slot store of operation records
// Assumes: Write and read addresses below twelve; other writes are ignored, other reads give zero
// Notes: Read data is registered, one cycle behind the read address
`include "cts_regs.svh"

module cts_rec_mem
   import cts_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic we,
   input wire logic [3:0] waddr,
   input cts_rec_s wdata,
   input wire logic [3:0] raddr,
   output cts_rec_s rdata
);

   cts_mem_s q;
   cts_mem_s d;

   always_comb
   begin
      d = q;
      if (we && waddr < `CTS_REC_N)
      begin
         d.mem[waddr] = wdata;
      end
      // Empty slots and bad indices read as zero
      d.rd = '0;
      if (raddr < `CTS_REC_N)
      begin
         d.rd = q.mem[raddr];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign rdata = q.rd;

endmodule

//--- src/cts_sup.sv
// Purpose: Current transformer circuit supervision with AXI4-Lite registers
// Assumes: Measured values arrive on ref_clk from the front end
// Notes: One program cycle is 5 ms; the alarm delay counts cycles
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "cts_regs.svh"

module cts_sup
   import cts_pkg::*;
#(
   parameter int unsigned CYC_LEN = `CTS_CYC_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rstn,
   input cts_meas_s meas,
   input wire logic blk_in,
   input wire logic [31:0] time_now,
   input wire logic [2:0] set_group,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic cts_start,
   output logic cts_alarm,
   output logic cts_blocked,
   output cts_evt_s evt
);

   cts_st_s q;
   cts_st_s d;
   cts_rec_s mem_rd;
   logic tick;
   logic [15:0] imax;
   logic [15:0] imin;
   logic hi_n;
   logic lo_n;
   logic unb_ok;
   logic seq_ok;
   logic res_ok;
   logic pick;
   logic [18:0] dly_min;

   localparam cts_cfg_s CFG_RST = '{
      hi: `CTS_RST_HI, lo: `CTS_RST_LO, ratio: `CTS_RST_RATIO,
      seq: `CTS_RST_SEQ, sdif: `CTS_RST_SDIF, dly: `CTS_RST_DLY,
      ctrl: `CTS_RST_CTRL, rsel: 4'h0};

   function automatic logic over_f(logic [15:0] v, logic [15:0] s,
                                   logic prev);
      if (prev)
      begin
         return (32'(v) * `CTS_PCT) >= (32'(s) * `CTS_HYS_LO);
      end
      return v > s;
   endfunction

   function automatic logic under_f(logic [15:0] v, logic [15:0] s,
                                    logic prev);
      if (prev)
      begin
         return (32'(v) * `CTS_PCT) <= (32'(s) * `CTS_HYS_HI);
      end
      return v < s;
   endfunction

   function automatic logic [15:0] absdiff(logic [15:0] a, logic [15:0] b);
      return (a > b) ? a - b : b - a;
   endfunction

   function automatic logic [31:0] strb_f(logic [31:0] old,
                                          logic [31:0] nw,
                                          logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic cts_evt_s mk_evt(logic [1:0] code, logic [1:0] sel,
                                       logic [31:0] stamp);
      cts_evt_s e;
      e.valid = 1'b1;
      e.code = code;
      // Even codes are on events, odd codes off events
      e.store = code[0] ? sel[1] : sel[0];
      e.stamp = stamp;
      return e;
   endfunction

   assign tick = (q.prg_cnt == 20'(CYC_LEN - 1));
   assign imax = (meas.i_l1 > meas.i_l2) ?
      ((meas.i_l1 > meas.i_l3) ? meas.i_l1 : meas.i_l3) :
      ((meas.i_l2 > meas.i_l3) ? meas.i_l2 : meas.i_l3);
   assign imin = (meas.i_l1 < meas.i_l2) ?
      ((meas.i_l1 < meas.i_l3) ? meas.i_l1 : meas.i_l3) :
      ((meas.i_l2 < meas.i_l3) ? meas.i_l2 : meas.i_l3);
   assign hi_n = over_f(imax, q.cfg.hi, q.hi_over);
   assign lo_n = under_f(imax, q.cfg.lo, q.lo_under);
   assign unb_ok = (32'(imax - imin) * `CTS_RSCALE) >=
                   (32'(q.cfg.ratio) * 32'(imax));
   assign seq_ok = (32'(meas.i_neg) * `CTS_RSCALE) >=
                   (32'(q.cfg.seq) * 32'(meas.i_pos));
   // Without a residual channel the wiring check cannot apply
   assign res_ok = !q.cfg.ctrl[`CTS_CTRL_RES] ||
                   (q.mag_diff >= q.cfg.sdif);
   assign pick = !hi_n && !lo_n && unb_ok && seq_ok && res_ok;
   // A zero delay still needs one whole program cycle of pick-up
   assign dly_min = (q.cfg.dly == 19'h0_0000) ? 19'h0_0001 : q.cfg.dly;

   always_comb
   begin
      logic [31:0] wv;
      logic [7:0] roff;
      logic [191:0] rv;
      logic ev_alm;
      logic ev_blk;
      wv = 32'h0000_0000;
      roff = 8'h00;
      rv = mem_rd;
      d = q;
      d.evt.valid = 1'b0;
      d.we = 1'b0;
      d.clr = 1'b0;
      d.eval = tick;
      d.prg_cnt = tick ? 20'h0_0000 : q.prg_cnt + 20'h0_0001;
      if (tick)
      begin
         d.blk_s = blk_in;
      end
      d.mag_diff = absdiff(meas.i_sum, meas.i_res);
      d.ang_diff = {1'b0, meas.ang_sum} - {1'b0, meas.ang_res};

      // Evaluation runs one cycle after the blocking sample
      if (q.eval)
      begin
         d.hi_over = hi_n;
         d.lo_under = lo_n;
         d.flt = {hi_n, lo_n, unb_ok, seq_ok};
         case (q.state)
            ST_IDLE:
            begin
               if (pick && q.blk_s)
               begin
                  d.state = ST_BLOCK;
                  d.blocked = 1'b1;
                  d.evt = mk_evt(`CTS_EV_BLK_ON,
                     q.cfg.ctrl[`CTS_CTRL_BSEL +: 2], time_now);
               end
               else if (pick)
               begin
                  d.state = ST_START;
                  d.start = 1'b1;
                  d.timer = 19'h0_0000;
               end
            end
            ST_START:
            begin
               if (!pick || q.blk_s)
               begin
                  d.state = ST_IDLE;
                  d.start = 1'b0;
                  d.timer = 19'h0_0000;
               end
               else
               begin
                  // Definite time only: one count per 5 ms cycle
                  d.timer = q.timer + 19'h0_0001;
                  if (d.timer >= dly_min)
                  begin
                     d.state = ST_ALARM;
                     d.alarm = 1'b1;
                     d.evt = mk_evt(`CTS_EV_ALM_ON,
                        q.cfg.ctrl[`CTS_CTRL_ASEL +: 2], time_now);
                  end
               end
            end
            ST_ALARM:
            begin
               if (!pick || q.blk_s)
               begin
                  d.state = ST_IDLE;
                  d.alarm = 1'b0;
                  d.start = 1'b0;
                  d.timer = 19'h0_0000;
                  d.evt = mk_evt(`CTS_EV_ALM_OFF,
                     q.cfg.ctrl[`CTS_CTRL_ASEL +: 2], time_now);
               end
            end
            ST_BLOCK:
            begin
               if (!pick || !q.blk_s)
               begin
                  d.state = ST_IDLE;
                  d.blocked = 1'b0;
                  d.evt = mk_evt(`CTS_EV_BLK_OFF,
                     q.cfg.ctrl[`CTS_CTRL_BSEL +: 2], time_now);
               end
            end
            default:
            begin
               d.state = ST_IDLE;
            end
         endcase
      end

      // On events take a record slot, overwriting the oldest
      if (d.evt.valid && !d.evt.code[0])
      begin
         d.we = 1'b1;
         d.waddr = q.wr_ptr;
         d.wr_ptr = (q.wr_ptr == `CTS_REC_N - 4'h1) ?
                    4'h0 : q.wr_ptr + 4'h1;
         if (q.rec_n != `CTS_REC_N)
         begin
            d.rec_n = q.rec_n + 4'h1;
         end
         d.wrec = '0;
         d.wrec.stamp = time_now;
         d.wrec.code = d.evt.code;
         d.wrec.i_l1 = meas.i_l1;
         d.wrec.i_l2 = meas.i_l2;
         d.wrec.i_l3 = meas.i_l3;
         d.wrec.i_res = meas.i_res;
         d.wrec.i_pos = meas.i_pos;
         d.wrec.i_neg = meas.i_neg;
         d.wrec.remain = (dly_min > d.timer) ? dly_min - d.timer
                                             : 19'h0_0000;
         d.wrec.fault = d.flt;
         d.wrec.group = set_group;
      end

      // A count landing with the clear is kept
      ev_alm = d.evt.valid && d.evt.code == `CTS_EV_ALM_ON;
      ev_blk = d.evt.valid && d.evt.code == `CTS_EV_BLK_ON;
      if (q.clr)
      begin
         d.alm_cnt = 16'(ev_alm);
         d.blk_cnt = 16'(ev_blk);
      end
      else
      begin
         d.alm_cnt = q.alm_cnt + 16'(ev_alm);
         d.blk_cnt = q.blk_cnt + 16'(ev_blk);
      end

      if (q.awready && s_axi_awvalid)
      begin
         d.aw_have = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (q.wready && s_axi_wvalid)
      begin
         d.w_have = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready)
      begin
         d.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.bvalid)
      begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = 2'h0;
         case (q.awaddr)
            `CTS_A_CTRL:
            begin
               wv = strb_f({26'h0, q.cfg.ctrl}, q.wdata, q.wstrb);
               d.cfg.ctrl = {wv[5:1], 1'b0};
               d.clr = wv[`CTS_CTRL_CLR];
            end
            `CTS_A_HI:
            begin
               wv = strb_f({16'h0, q.cfg.hi}, q.wdata, q.wstrb);
               d.cfg.hi = wv[15:0];
            end
            `CTS_A_LO:
            begin
               wv = strb_f({16'h0, q.cfg.lo}, q.wdata, q.wstrb);
               d.cfg.lo = wv[15:0];
            end
            `CTS_A_RATIO:
            begin
               wv = strb_f({16'h0, q.cfg.ratio}, q.wdata, q.wstrb);
               d.cfg.ratio = wv[15:0];
            end
            `CTS_A_SEQ:
            begin
               wv = strb_f({16'h0, q.cfg.seq}, q.wdata, q.wstrb);
               d.cfg.seq = wv[15:0];
            end
            `CTS_A_SDIF:
            begin
               wv = strb_f({16'h0, q.cfg.sdif}, q.wdata, q.wstrb);
               d.cfg.sdif = wv[15:0];
            end
            `CTS_A_DLY:
            begin
               wv = strb_f({13'h0, q.cfg.dly}, q.wdata, q.wstrb);
               d.cfg.dly = wv[18:0];
            end
            `CTS_A_RSEL:
            begin
               wv = strb_f({28'h0, q.cfg.rsel}, q.wdata, q.wstrb);
               d.cfg.rsel = wv[3:0];
            end
            `CTS_A_STAT, `CTS_A_CNT, `CTS_A_MAG, `CTS_A_ANG:
            begin
               d.bresp = 2'h0;
            end
            default:
            begin
               d.bresp = 2'h2;
            end
         endcase
      end
      d.awready = !d.aw_have;
      d.wready = !d.w_have;

      if (q.rvalid && s_axi_rready)
      begin
         d.rvalid = 1'b0;
      end
      if (q.arready && s_axi_arvalid)
      begin
         d.araddr = s_axi_araddr;
         d.rstage = 1'b1;
      end
      // Extra stage lets the record store settle after a select write
      if (q.rstage)
      begin
         d.rstage = 1'b0;
         d.rvalid = 1'b1;
         d.rresp = 2'h0;
         d.rdata = 32'h0000_0000;
         case (q.araddr)
            `CTS_A_CTRL: d.rdata = {26'h0, q.cfg.ctrl};
            `CTS_A_HI: d.rdata = {16'h0, q.cfg.hi};
            `CTS_A_LO: d.rdata = {16'h0, q.cfg.lo};
            `CTS_A_RATIO: d.rdata = {16'h0, q.cfg.ratio};
            `CTS_A_SEQ: d.rdata = {16'h0, q.cfg.seq};
            `CTS_A_SDIF: d.rdata = {16'h0, q.cfg.sdif};
            `CTS_A_DLY: d.rdata = {13'h0, q.cfg.dly};
            `CTS_A_STAT: d.rdata = {16'h0, q.rec_n, q.wr_ptr, q.flt,
                                    1'b0, q.blk_s, 2'(q.state)};
            `CTS_A_CNT: d.rdata = {q.blk_cnt, q.alm_cnt};
            `CTS_A_MAG: d.rdata = {16'h0, q.mag_diff};
            `CTS_A_ANG: d.rdata = {{15{q.ang_diff[16]}}, q.ang_diff};
            `CTS_A_RSEL: d.rdata = {28'h0, q.cfg.rsel};
            default:
            begin
               roff = q.araddr - `CTS_A_REC0;
               if (q.araddr >= `CTS_A_REC0 && q.araddr <= `CTS_A_REC5
                   && q.araddr[1:0] == 2'h0)
               begin
                  d.rdata = rv[{roff[4:2], 5'h00} +: 32];
               end
               else
               begin
                  d.rresp = 2'h2;
               end
            end
         endcase
      end
      d.arready = !d.rstage && !d.rvalid;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         q <= '0;
         q.cfg <= CFG_RST;
      end
      else
      begin
         q <= d;
      end
   end

   cts_rec_mem u_mem (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .we(q.we),
      .waddr(q.waddr),
      .wdata(q.wrec),
      .raddr(q.cfg.rsel),
      .rdata(mem_rd)
   );

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign cts_start = q.start;
   assign cts_alarm = q.alarm;
   assign cts_blocked = q.blocked;
   assign evt = q.evt;

endmodule

//--- bench/cts_sup_monitor.sv
// Purpose: Port-level checks of the supervision block
// Assumes: Bound into every cts_sup instance
// Notes: Delay check counts clocks spent with start high
`include "cts_regs.svh"

module cts_sup_monitor
   import cts_pkg::*;
#(
   parameter int unsigned CYC_LEN = 20
)
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic cts_start,
   input wire logic cts_alarm,
   input wire logic cts_blocked,
   input cts_evt_s evt
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [31:0] run_q;
   logic [31:0] run_d;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   always_comb
   begin
      run_d = cts_start ? run_q + 32'h0000_0001 : 32'h0000_0000;
   end

   always_ff @(posedge ref_clk)
   begin
      run_q <= rstn ? run_d : 32'h0000_0000;
   end

   chk_alarm_in_start: assert property
      (cts_alarm |-> cts_start)
      else $error("alarm without start");
   chk_alarm_delay: assert property
      ($rose(cts_alarm) |-> run_q >= CYC_LEN - 1)
      else $error("alarm before one program cycle");
   chk_blk_no_start: assert property
      (cts_blocked |-> !cts_start)
      else $error("blocked and start together");
   chk_blk_via_idle: assert property
      ($rose(cts_blocked) |-> !$past(cts_start))
      else $error("blocked straight from start");
   chk_evt_one_cycle: assert property
      (evt.valid |=> !evt.valid)
      else $error("event longer than one cycle");
   chk_alarm_on_evt: assert property
      ($rose(cts_alarm) |-> evt.valid && evt.code == `CTS_EV_ALM_ON)
      else $error("no alarm on event");
   chk_alarm_off_evt: assert property
      ($fell(cts_alarm) |-> evt.valid && evt.code == `CTS_EV_ALM_OFF)
      else $error("no alarm off event");
   chk_block_on_evt: assert property
      ($rose(cts_blocked) |-> evt.valid && evt.code == `CTS_EV_BLK_ON)
      else $error("no block on event");
   chk_read_hold: assert property
      (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer not held");
   chk_write_hold: assert property
      (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer not held");
endmodule

bind cts_sup cts_sup_monitor #(.CYC_LEN(CYC_LEN)) u_mon (
   .ref_clk, .rstn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cts_start, .cts_alarm,
   .cts_blocked, .evt);

//--- bench/cts_front.sv
// Purpose: Front end model giving currents and the blocking level
// Assumes: Currents in 0.01 x In, angles in 0.01 deg
// Notes: Combinational, follows selections the bench makes after edges
module cts_front
   import cts_pkg::*;
(
   input wire logic [1:0] sel,
   input wire logic blk_req,
   output cts_meas_s meas,
   output logic blk_in
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [79:0] v;

   always_comb
   begin
      // Bench raises blocking right after start, far ahead of expiry
      blk_in = blk_req;
      meas.i_sum = 16'h001E;
      meas.i_res = 16'h000A;
      meas.ang_sum = 16'h0064;
      meas.ang_res = 16'h012C;
      // Balanced, first phase lost, overcurrent, low current
      case (sel)
         2'h0: v = 80'h0064_0064_0064_0064_0000;
         2'h1: v = 80'h0000_0064_0064_0043_0021;
         2'h2: v = 80'h01F4_0064_0064_00E9_0085;
         default: v = 80'h0005_0001_0001_0002_0002;
      endcase
      {meas.i_l1, meas.i_l2, meas.i_l3, meas.i_pos, meas.i_neg} = v;
   end
endmodule

//--- bench/testbench.sv
// Purpose: Self-checking bench for the supervision block
// Assumes: Program cycle cut to CYC clocks, alarm delay set to 3 steps
// Notes: Bus answers are sampled on the falling edge
`include "cts_regs.svh"

module testbench
   import cts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int CYC = 20;
   logic ref_clk, rstn, blk_in, blk_req, cts_start, cts_alarm, cts_blocked;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, time_now;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, sel;
   logic [2:0] set_group;
   cts_meas_s meas;
   cts_evt_s evt;
   int error_cnt = 0;
   int n_compared = 0;

   cts_front u_front (.sel, .blk_req, .meas, .blk_in);

   cts_sup #(.CYC_LEN(CYC)) u_dut (.ref_clk, .rstn, .meas, .blk_in,
      .time_now, .set_group, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .cts_start, .cts_alarm, .cts_blocked,
      .evt);

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
      time_now <= time_now + 32'h0000_0001;

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         error_cnt++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic aw, w, done;
      logic [1:0] r;
      done = 1'b0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int i = 0; i < 100 && !done; i++)
      begin
         @(negedge ref_clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         done = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge ref_clk);
         if (aw)
            s_axi_awvalid <= 1'b0;
         if (w)
            s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", r, er);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic ar, done;
      done = 1'b0;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int i = 0; i < 100 && !done; i++)
      begin
         @(negedge ref_clk);
         ar = s_axi_arvalid && s_axi_arready;
         done = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge ref_clk);
         if (ar)
            s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask

   task automatic rdc(input string what, input logic [7:0] a,
      input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(what, d, exp);
   endtask

   task automatic drive(input logic [1:0] s, input logic b);
      @(posedge ref_clk);
      sel <= s;
      blk_req <= b;
   endtask

   // Bounded wait; k is the count of falling edges passed, or n + 1 on timeout
   task automatic wait_lvl(ref logic s, input logic lvl, input int n,
      output int k);
      for (k = 1; k <= n; k++)
      begin
         @(negedge ref_clk);
         if (s === lvl)
            break;
      end
   endtask

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rdc("hi reset", `CTS_A_HI, 32'h0000_0078);
      rdc("dly reset", `CTS_A_DLY, 32'h0000_0064);
      rd(8'h50, d, r);
      chk("unmapped rresp", r, 32'h0000_0002);
      rdc("mag diff", `CTS_A_MAG, 32'h0000_0014);
      rdc("ang diff", `CTS_A_ANG, 32'hFFFF_FF38);
      wr(`CTS_A_DLY, 32'h0000_0003, 2'h0);
      // Alarm on events stored, alarm off events not
      wr(`CTS_A_CTRL, 32'h0000_0034, 2'h0);
      $display("done regs");
   endtask

   task automatic t_alarm();
      int k;
      drive(2'h1, 1'b0);
      wait_lvl(cts_start, 1'b1, 3 * CYC, k);
      chk("start", cts_start, 32'h0000_0001);
      wait_lvl(cts_alarm, 1'b1, 5 * CYC, k);
      chk("alarm delay", k, 3 * CYC);
      chk("alarm on", {evt.valid, evt.code, evt.store}, 4'h9);
      drive(2'h0, 1'b0);
      wait_lvl(cts_alarm, 1'b0, 2 * CYC, k);
      chk("alarm off", {evt.valid, evt.code, evt.store}, 4'hA);
      chk("start drop", cts_start, 32'h0000_0000);
      $display("done alarm");
   endtask

   task automatic t_limits();
      int k;
      // Residual gap 20 below a limit of 21 must hold off pick-up
      wr(`CTS_A_SDIF, 32'h0000_0015, 2'h0);
      wr(`CTS_A_CTRL, 32'h0000_0036, 2'h0);
      for (int p = 1; p < 4; p++)
      begin
         drive(p[1:0], 1'b0);
         wait_lvl(cts_start, 1'b1, 4 * CYC, k);
         chk("limit idle", cts_start, 32'h0000_0000);
      end
      wr(`CTS_A_CTRL, 32'h0000_0034, 2'h0);
      drive(2'h0, 1'b0);
      $display("done limits");
   endtask

   task automatic t_block();
      int k;
      drive(2'h1, 1'b1);
      wait_lvl(cts_blocked, 1'b1, 3 * CYC, k);
      chk("blocked", {cts_blocked, cts_start}, 32'h0000_0002);
      drive(2'h1, 1'b0);
      wait_lvl(cts_start, 1'b1, 4 * CYC, k);
      chk("restart", cts_start, 32'h0000_0001);
      drive(2'h1, 1'b1);
      wait_lvl(cts_start, 1'b0, 2 * CYC, k);
      chk("start cleared", {cts_start, cts_alarm}, 32'h0000_0000);
      wait_lvl(cts_blocked, 1'b1, 3 * CYC, k);
      drive(2'h0, 1'b0);
      wait_lvl(cts_blocked, 1'b0, 3 * CYC, k);
      $display("done block");
   endtask

   task automatic t_count();
      logic [31:0] d;
      logic [1:0] r;
      rdc("counters", `CTS_A_CNT, 32'h0002_0001);
      rd(`CTS_A_STAT, d, r);
      chk("records", d[15:8], 8'h33);
      wr(`CTS_A_RSEL, 32'h0000_0000, 2'h0);
      rdc("rec phases", `CTS_A_REC0 + 8'h04, 32'h0064_0000);
      rd(`CTS_A_REC5, d, r);
      chk("rec group", {d[8:6], d[1:0]}, {3'h5, `CTS_EV_ALM_ON});
      wr(`CTS_A_RSEL, 32'h0000_0002, 2'h0);
      rd(`CTS_A_REC5, d, r);
      chk("rec2 code", d[1:0], `CTS_EV_BLK_ON);
      wr(`CTS_A_CTRL, 32'h0000_0035, 2'h0);
      rdc("counters clr", `CTS_A_CNT, 32'h0000_0000);
      $display("done count");
   endtask

   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, blk_req, rstn, sel} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, time_now} = '0;
      s_axi_wstrb = 4'hF;
      set_group = 3'h5;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      t_regs();
      t_alarm();
      t_limits();
      t_block();
      t_count();
      end_of_test();
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      end_of_test();
   end
endmodule
